// *** logic/acq_dma_pkg.sv ***
package acq_dma_pkg;

    // Register offsets (word index on the plain register port)
    localparam logic [3:0] OFS_CONTROL = 4'h0;
    localparam logic [3:0] OFS_ADDRESS = 4'h1;
    localparam logic [3:0] OFS_COUNT = 4'h2;
    localparam logic [3:0] OFS_STEP = 4'h3;
    localparam logic [3:0] OFS_STROBE_SEL = 4'h4;
    localparam logic [3:0] OFS_TRIG_A = 4'h5;
    localparam logic [3:0] OFS_TRIG_B = 4'h6;
    localparam logic [3:0] OFS_SAMPLE_HOLD = 4'h7;
    localparam logic [3:0] OFS_STATUS = 4'h8;
    localparam logic [3:0] OFS_HOST_DATA = 4'h9;

    // Control register fields
    localparam int CTL_START_BIT = 0;
    localparam int CTL_SWEEP_OWNER_BIT = 1;

    // Strobe select fields: bit0 main/window, bits 2:1 channel enables, bit3 pipe pair
    localparam int SEL_WINDOW_BIT = 0;
    localparam int SEL_CH1_BIT = 1;
    localparam int SEL_CH2_BIT = 2;
    localparam int SEL_PAIR_BIT = 3;

    // Reset values
    localparam logic [15:0] ADDRESS_RESET = 16'h0000;
    localparam logic [15:0] STEP_RESET = 16'h0001;
    localparam logic [3:0] STROBE_SEL_RESET = 4'h2;

    // Widths
    localparam int SAMPLE_WIDTH = 8;
    localparam int WORD_WIDTH = 16;
    localparam int BANK_BYTES = 262144;

    typedef enum logic [1:0] {
        ST_PROGRAM,
        ST_STROBE,
        ST_WRITE
    } dma_state_type;

    // Per-bank write port to sample RAM
    typedef struct packed {
        logic we;
        logic [15:0] addr;
        logic [15:0] data;
    } bank_write_type;

    // Demux strobes: one per pipe plus record selection
    typedef struct packed {
        logic [3:0] pipe;
        logic main_rec;
        logic window_rec;
    } demux_strobe_type;

endpackage

// *** logic/acquisition_dma_controller.sv ***
// The implementer's own choices: strobed register access and the register offsets.
`timescale 1ns/10ps

module acquisition_dma_controller
    import acq_dma_pkg::*;
#(
    parameter int COUNT_WIDTH = 16
)
(
    // Clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // Host register port
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [15:0] reg_rdata,
    // Demux side
    input wire logic [7:0] pipe_data_a,
    input wire logic [7:0] pipe_data_b,
    output demux_strobe_type demux_strobe,
    // Sample RAM banks
    output bank_write_type bank1_write,
    output bank_write_type bank2_write,
    output logic host_bank_enable,
    // Glue outputs
    output logic transfer_mode_select,
    output logic sweep_owner_select,
    output logic trig_a_clock,
    output logic trig_b_clock,
    output logic sample_hold_load,
    output logic [15:0] sample_hold_bits,
    // Trigger readback
    input wire logic [15:0] trig_a_readback,
    input wire logic [15:0] trig_b_readback
);

    // Counter must fit the 16-bit register word
    if (COUNT_WIDTH < 1 || COUNT_WIDTH > 16)
    begin
        $error("COUNT_WIDTH must be 1..16");
    end

    dma_state_type state_r;
    logic [15:0] dma_memory_address_r;
    logic [COUNT_WIDTH-1:0] transfer_counter_r;
    logic [15:0] address_step_value_r;
    logic [3:0] strobe_select_reg_r;
    logic sweep_owner_r;
    logic [7:0] pa_meta_r, pa_sync_r, pb_meta_r, pb_sync_r;
    logic [15:0] tra_meta_r, tra_sync_r, trb_meta_r, trb_sync_r;
    logic setup_ok;
    logic start_cmd;
    logic ch1_en, ch2_en;

    // Setup writes are only honoured while in program mode
    assign setup_ok = reg_write && (state_r == ST_PROGRAM);
    assign start_cmd = setup_ok && reg_addr == OFS_CONTROL && reg_wdata[CTL_START_BIT];
    assign ch1_en = strobe_select_reg_r[SEL_CH1_BIT];
    assign ch2_en = strobe_select_reg_r[SEL_CH2_BIT];

    // Samples cross from demux timing, so synchronise first
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            pa_meta_r <= 8'h00;
            pa_sync_r <= 8'h00;
            pb_meta_r <= 8'h00;
            pb_sync_r <= 8'h00;
        end
        else
        begin
            pa_meta_r <= pipe_data_a;
            pa_sync_r <= pa_meta_r;
            pb_meta_r <= pipe_data_b;
            pb_sync_r <= pb_meta_r;
        end
    end

    // Trigger readback comes from the hybrids; must be steady two cycles before a read
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            tra_meta_r <= 16'h0000;
            tra_sync_r <= 16'h0000;
            trb_meta_r <= 16'h0000;
            trb_sync_r <= 16'h0000;
        end
        else
        begin
            tra_meta_r <= trig_a_readback;
            tra_sync_r <= tra_meta_r;
            trb_meta_r <= trig_b_readback;
            trb_sync_r <= trb_meta_r;
        end
    end

    // Transfer sequencer: strobe cycle then write cycle
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
            state_r <= ST_PROGRAM;
        else
        begin
            unique case (state_r)
                ST_PROGRAM:
                    if (start_cmd && transfer_counter_r != '0)
                        state_r <= ST_STROBE;
                ST_STROBE:
                    state_r <= ST_WRITE;
                ST_WRITE:
                    if (transfer_counter_r == COUNT_WIDTH'(1))
                        state_r <= ST_PROGRAM;
                    else
                        state_r <= ST_STROBE;
            endcase
        end
    end

    // Mode output follows the sequencer
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
            transfer_mode_select <= 1'b0;
        else
            transfer_mode_select <= (state_r != ST_PROGRAM) || (start_cmd && transfer_counter_r != '0);
    end

    // Address: host load in program mode, stepped after each transfer
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
            dma_memory_address_r <= ADDRESS_RESET;
        else if (setup_ok && reg_addr == OFS_ADDRESS)
            dma_memory_address_r <= reg_wdata;
        else if (state_r == ST_WRITE)
            dma_memory_address_r <= dma_memory_address_r + address_step_value_r;
    end

    // Counter: host load, one decrement per completed transfer
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
            transfer_counter_r <= '0;
        else if (setup_ok && reg_addr == OFS_COUNT)
            transfer_counter_r <= reg_wdata[COUNT_WIDTH-1:0];
        else if (state_r == ST_WRITE)
            transfer_counter_r <= transfer_counter_r - COUNT_WIDTH'(1);
    end

    // Step, strobe select and sweep owner setup registers
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            address_step_value_r <= STEP_RESET;
            strobe_select_reg_r <= STROBE_SEL_RESET;
            sweep_owner_r <= 1'b0;
        end
        else if (setup_ok)
        begin
            if (reg_addr == OFS_STEP)
                address_step_value_r <= reg_wdata;
            if (reg_addr == OFS_STROBE_SEL)
                strobe_select_reg_r <= reg_wdata[3:0];
            if (reg_addr == OFS_CONTROL)
                sweep_owner_r <= reg_wdata[CTL_SWEEP_OWNER_BIT];
        end
    end

    // Demux strobes decoded from the transfer read cycle; pair bit picks 1+3 or 2+4
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
            demux_strobe <= '0;
        else
        begin
            demux_strobe <= '0;
            if (state_r == ST_STROBE)
            begin
                // One pipe per channel, so 1+2 or 3+4 cannot coincide
                demux_strobe.pipe[0] <= ch1_en && !strobe_select_reg_r[SEL_PAIR_BIT];
                demux_strobe.pipe[1] <= ch1_en && strobe_select_reg_r[SEL_PAIR_BIT];
                demux_strobe.pipe[2] <= ch2_en && !strobe_select_reg_r[SEL_PAIR_BIT];
                demux_strobe.pipe[3] <= ch2_en && strobe_select_reg_r[SEL_PAIR_BIT];
                // Single select bit keeps main and window exclusive
                demux_strobe.main_rec <= !strobe_select_reg_r[SEL_WINDOW_BIT];
                demux_strobe.window_rec <= strobe_select_reg_r[SEL_WINDOW_BIT];
            end
        end
    end

    // Bank writes: each channel into its own bank, same cycle, zero-extended
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            bank1_write <= '0;
            bank2_write <= '0;
        end
        else
        begin
            bank1_write.we <= (state_r == ST_WRITE) && ch1_en;
            bank2_write.we <= (state_r == ST_WRITE) && ch2_en;
            bank1_write.addr <= dma_memory_address_r;
            bank2_write.addr <= dma_memory_address_r;
            bank1_write.data <= {8'h00, pa_sync_r};
            bank2_write.data <= {8'h00, pb_sync_r};
        end
    end

    // Host may use the banks only in program mode
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
            host_bank_enable <= 1'b1;
        else
            host_bank_enable <= (state_r == ST_PROGRAM) && !start_cmd;
    end

    // Trigger clocks and sample/hold load pulses, one cycle per write
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            trig_a_clock <= 1'b0;
            trig_b_clock <= 1'b0;
            sample_hold_load <= 1'b0;
            sample_hold_bits <= 16'h0000;
            sweep_owner_select <= 1'b0;
        end
        else
        begin
            trig_a_clock <= reg_write && reg_addr == OFS_TRIG_A;
            trig_b_clock <= reg_write && reg_addr == OFS_TRIG_B;
            sample_hold_load <= reg_write && reg_addr == OFS_SAMPLE_HOLD;
            if (reg_write && reg_addr == OFS_SAMPLE_HOLD)
                sample_hold_bits <= reg_wdata;
            sweep_owner_select <= sweep_owner_r;
        end
    end

    // Read data, valid the cycle after the read strobe; unmapped reads zero
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
            reg_rdata <= 16'h0000;
        else if (reg_read)
        begin
            unique case (reg_addr)
                OFS_CONTROL: reg_rdata <= {14'h0000, sweep_owner_r, 1'b0};
                OFS_ADDRESS: reg_rdata <= dma_memory_address_r;
                OFS_COUNT: reg_rdata <= 16'(transfer_counter_r);
                OFS_STEP: reg_rdata <= address_step_value_r;
                OFS_STROBE_SEL: reg_rdata <= {12'h000, strobe_select_reg_r};
                OFS_TRIG_A: reg_rdata <= tra_sync_r;
                OFS_TRIG_B: reg_rdata <= trb_sync_r;
                OFS_SAMPLE_HOLD: reg_rdata <= sample_hold_bits;
                OFS_STATUS: reg_rdata <= {14'h0000, state_r};
                default: reg_rdata <= 16'h0000;
            endcase
        end
        else
            reg_rdata <= 16'h0000;
    end

    // Checks
    a_pipe_pair_excl: assert property (@(posedge clock) disable iff (!reset_n)
        !(demux_strobe.pipe[0] && demux_strobe.pipe[1]) && !(demux_strobe.pipe[2] && demux_strobe.pipe[3]))
        else $error("paired pipe strobes together");
    a_main_window_excl: assert property (@(posedge clock) disable iff (!reset_n)
        !(demux_strobe.main_rec && demux_strobe.window_rec))
        else $error("main and window strobes together");
    a_start_raises_mode: assert property (@(posedge clock) disable iff (!reset_n)
        start_cmd && transfer_counter_r != '0 |=> transfer_mode_select)
        else $error("start did not enter transfer mode");
    a_addr_step: assert property (@(posedge clock) disable iff (!reset_n)
        state_r == ST_WRITE |=> dma_memory_address_r == $past(dma_memory_address_r) + $past(address_step_value_r))
        else $error("address not stepped");
    a_count_down: assert property (@(posedge clock) disable iff (!reset_n)
        state_r == ST_WRITE |=> transfer_counter_r == $past(transfer_counter_r) - COUNT_WIDTH'(1))
        else $error("counter not decremented");
    a_zero_stops: assert property (@(posedge clock) disable iff (!reset_n)
        state_r == ST_WRITE && transfer_counter_r == COUNT_WIDTH'(1) |=> state_r == ST_PROGRAM ##1 !transfer_mode_select)
        else $error("did not stop at zero");
    a_trig_pulse: assert property (@(posedge clock) disable iff (!reset_n)
        reg_write && reg_addr == OFS_TRIG_A |=> trig_a_clock)
        else $error("trigger A pulse missing");
    a_host_bank_lock: assert property (@(posedge clock) disable iff (!reset_n)
        transfer_mode_select |-> !host_bank_enable)
        else $error("host bank access in transfer mode");
    a_bank_same_cycle: assert property (@(posedge clock) disable iff (!reset_n)
        $rose(transfer_mode_select) && ch1_en && ch2_en |-> ##2 (bank1_write.we && bank2_write.we))
        else $error("banks not written together");
    a_trig_b_pulse: assert property (@(posedge clock) disable iff (!reset_n)
        reg_write && reg_addr == OFS_TRIG_B |=> trig_b_clock)
        else $error("trigger B pulse missing");
    a_hold_load: assert property (@(posedge clock) disable iff (!reset_n)
        reg_write && reg_addr == OFS_SAMPLE_HOLD |=> sample_hold_load && sample_hold_bits == $past(reg_wdata))
        else $error("sample hold load missing");
    a_setup_refused: assert property (@(posedge clock) disable iff (!reset_n)
        reg_write && state_r != ST_PROGRAM |=> $stable(address_step_value_r) && $stable(strobe_select_reg_r))
        else $error("setup changed outside program mode");
    a_strobe_in_mode: assert property (@(posedge clock) disable iff (!reset_n)
        |demux_strobe.pipe |-> transfer_mode_select)
        else $error("demux strobe outside transfer mode");
    a_strobe_pulse: assert property (@(posedge clock) disable iff (!reset_n)
        |demux_strobe.pipe |=> !(|demux_strobe.pipe))
        else $error("demux strobe longer than one cycle");
    a_bank_widen: assert property (@(posedge clock) disable iff (!reset_n)
        bank1_write.we |-> bank1_write.data == {8'h00, $past(pa_sync_r)})
        else $error("bank 1 sample not widened");
    a_mode_exit: assert property (@(posedge clock) disable iff (!reset_n)
        $fell(transfer_mode_select) |-> host_bank_enable)
        else $error("host bank access not restored");
    c_pair_select: cover property (@(posedge clock) demux_strobe.pipe[1] || demux_strobe.pipe[3]);
    c_dual_transfer: cover property (@(posedge clock) bank1_write.we && bank2_write.we);
    c_single_transfer: cover property (@(posedge clock) bank1_write.we && !bank2_write.we);
    c_run_complete: cover property (@(posedge clock) $fell(transfer_mode_select));
    c_window_strobe: cover property (@(posedge clock) demux_strobe.window_rec);

endmodule

// *** verif/demux_pipe_model.sv ***
`timescale 1ns/10ps

// Acquisition pipes as seen from the demux strobe side
module demux_pipe_model
    import acq_dma_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // Strobes and sample source
    input demux_strobe_type demux_strobe,
    input wire logic [7:0] sample_a,
    input wire logic [7:0] sample_b,
    // Pipe outputs
    output logic [7:0] pipe_data_a,
    output logic [7:0] pipe_data_b,
    output int strobe_total
);
    // Channel 1 pipes feed side a, channel 2 pipes side b; held steady per run
    assign pipe_data_a = sample_a;
    assign pipe_data_b = sample_b;

    // Strobe events counted so the bench can match them to the transfer count
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
            strobe_total <= 0;
        else if (|demux_strobe.pipe)
            strobe_total <= strobe_total + 1;
    end
endmodule

// *** verif/tb.sv ***
`timescale 1ns/10ps

`define CHK(g, e) begin checked++; if ((g) !== (e)) begin error_cnt++; \
    $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end

module tb;
    import acq_dma_pkg::*;
    logic clock = 1'b0;
    logic reset_n = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic [15:0] reg_rdata, sample_hold_bits;
    logic [15:0] tra = 16'h0000;
    logic [15:0] trb = 16'h0000;
    logic [7:0] sa = 8'h00;
    logic [7:0] sb = 8'h00;
    logic [7:0] pa, pb;
    demux_strobe_type demux_strobe;
    bank_write_type bank1_write, bank2_write;
    logic host_bank_enable, transfer_mode_select, sweep_owner_select;
    logic trig_a_clock, trig_b_clock, sample_hold_load;
    int strobe_total, error_cnt = 0, checked = 0, seed = 80100, nwr = 0;
    logic running = 1'b0;
    logic [3:0] sel = 4'h0;
    logic [15:0] exp_addr, step, d;

    acquisition_dma_controller uut (.clock(clock), .reset_n(reset_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
        .pipe_data_a(pa), .pipe_data_b(pb), .demux_strobe(demux_strobe), .bank1_write(bank1_write),
        .bank2_write(bank2_write), .host_bank_enable(host_bank_enable),
        .transfer_mode_select(transfer_mode_select), .sweep_owner_select(sweep_owner_select),
        .trig_a_clock(trig_a_clock), .trig_b_clock(trig_b_clock), .sample_hold_load(sample_hold_load),
        .sample_hold_bits(sample_hold_bits), .trig_a_readback(tra), .trig_b_readback(trb));

    demux_pipe_model pipes (.clock(clock), .reset_n(reset_n), .demux_strobe(demux_strobe),
        .sample_a(sa), .sample_b(sb), .pipe_data_a(pa), .pipe_data_b(pb), .strobe_total(strobe_total));

    // Clock, 40 ns period
    initial
    begin
        forever #20 clock = ~clock;
    end

    // Register port cycles, one-cycle strobes
    task automatic wr(input logic [3:0] a, input logic [15:0] v);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= v;
        reg_write <= 1'b1;
        @(posedge clock);
        reg_write <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a);
        @(posedge clock);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clock);
        reg_read <= 1'b0;
        #1 d = reg_rdata;
    endtask

    task automatic give_verdict;
        $display("checked=%0d error_cnt=%0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // Settled-time watch on strobes and bank writes
    always @(negedge clock)
    begin
        if (reset_n)
        begin
            `CHK(demux_strobe.main_rec & demux_strobe.window_rec, 1'b0)
            `CHK(|demux_strobe.pipe & ~transfer_mode_select, 1'b0)
            if (|demux_strobe.pipe)
            begin
                `CHK(demux_strobe.pipe, {sel[2] & sel[3], sel[2] & ~sel[3], sel[1] & sel[3], sel[1] & ~sel[3]})
                `CHK({demux_strobe.main_rec, demux_strobe.window_rec}, {~sel[0], sel[0]})
            end
            if (bank1_write.we | bank2_write.we)
            begin
                `CHK({bank1_write.we, bank2_write.we}, {sel[1], sel[2]})
                if (sel[1])
                    `CHK({bank1_write.addr, bank1_write.data}, {exp_addr, 8'h00, sa})
                if (sel[2])
                    `CHK({bank2_write.addr, bank2_write.data}, {exp_addr, 8'h00, sb})
                exp_addr = exp_addr + step;
                nwr++;
            end
        end
    end

    // One programmed transfer run, with a refused address write in mid-run
    task automatic run_dma(input logic [15:0] cnt);
        logic [15:0] a0;
        int s0;
        a0 = 16'($random(seed));
        step = {13'h0000, 3'($random(seed))};
        sel = 4'($random(seed));
        if (sel[2:1] == 2'b00)
            sel[1] = 1'b1;
        sa <= 8'($random(seed));
        sb <= 8'($random(seed));
        wr(OFS_ADDRESS, a0);
        wr(OFS_STEP, step);
        wr(OFS_STROBE_SEL, {12'h000, sel});
        wr(OFS_COUNT, cnt);
        rd(OFS_COUNT);
        `CHK(d, cnt)
        exp_addr = a0;
        nwr = 0;
        s0 = strobe_total;
        wr(OFS_CONTROL, 16'h0001);
        #1 `CHK({transfer_mode_select, host_bank_enable}, 2'b10)
        wr(OFS_ADDRESS, 16'hBEEF);
        for (int k = 0; k < 8 * cnt + 20 && transfer_mode_select; k++)
            @(negedge clock);
        `CHK({transfer_mode_select, host_bank_enable}, 2'b01)
        `CHK(nwr, int'(cnt))
        `CHK(strobe_total - s0, int'(cnt))
        rd(OFS_ADDRESS);
        `CHK(d, 16'(a0 + cnt * step))
    endtask

    // Main sequence
    initial
    begin
        repeat (6) @(posedge clock);
        reset_n <= 1'b1;
        `CHK({transfer_mode_select, host_bank_enable}, 2'b01)
        wr(4'hA, 16'hFFFF);
        rd(OFS_ADDRESS);
        `CHK(d, ADDRESS_RESET)
        rd(OFS_STEP);
        `CHK(d, STEP_RESET)
        rd(OFS_STROBE_SEL);
        `CHK(d, {12'h000, STROBE_SEL_RESET})
        // Owner select trails its setup bit by one register stage
        wr(OFS_CONTROL, 16'h0002);
        @(posedge clock);
        #1 `CHK({sweep_owner_select, transfer_mode_select}, 2'b10)
        wr(OFS_CONTROL, 16'h0000);
        @(posedge clock);
        #1 `CHK(sweep_owner_select, 1'b0)
        for (int i = 0; i < 2; i++)
        begin
            tra <= 16'($random(seed));
            trb <= 16'($random(seed));
            wr(i ? OFS_TRIG_B : OFS_TRIG_A, 16'($random(seed)));
            #1 `CHK({trig_a_clock, trig_b_clock}, i ? 2'b01 : 2'b10)
            @(posedge clock);
            #1 `CHK({trig_a_clock, trig_b_clock}, 2'b00)
            rd(i ? OFS_TRIG_B : OFS_TRIG_A);
            `CHK(d, i ? trb : tra)
        end
        d = 16'($random(seed));
        wr(OFS_SAMPLE_HOLD, d);
        #1 `CHK({sample_hold_load, sample_hold_bits}, {1'b1, d})
        @(posedge clock);
        #1 `CHK(sample_hold_load, 1'b0)
        wr(OFS_COUNT, 16'h0000);
        wr(OFS_CONTROL, 16'h0001);
        @(negedge clock);
        `CHK(transfer_mode_select, 1'b0)
        for (int i = 0; i < 8; i++)
            run_dma(i < 2 ? 16'(i + 1) : 16'(3 + ($random(seed) & 5)));
        give_verdict();
    end

    // Watchdog against a hung transfer
    initial
    begin
        #200000;
        error_cnt++;
        give_verdict();
    end
endmodule
